/* core/usb_out_ep_regs.svh */
// register offsets, field positions and reset values of the output endpoint
`ifndef USB_OUT_EP_REGS_SVH
`define USB_OUT_EP_REGS_SVH
// register addresses in the external data space
`define OFS_OUT_CONFIG        16'hf018
`define OFS_OUT_X_BASE        16'hf019
`define OFS_OUT_X_COUNT_LOW   16'hf01a
`define OFS_OUT_X_COUNT_HIGH  16'hf01b
`define OFS_OUT_Y_BASE        16'hf01d
`define OFS_OUT_Y_COUNT_LOW   16'hf01e
`define OFS_OUT_Y_COUNT_HIGH  16'hf01f
// field positions
`define BIT_FULL_FLAG         7
`define BIT_EXPECTED_TOGGLE   5
`define BIT_DOUBLE_BUFFER     4
`define BIT_RESET_TOGGLE      1
// buffer address framing
`define ADDR_TOP_NIBBLE       4'he
`define ADDR_LOW_NIBBLE       4'h0
// reset values
`define RST_BYTE              8'h00
`define RST_COUNT             11'h000
// data path buffering
`define RX_FIFO_DEPTH         8
`define RX_FIFO_WIDTH         8
`endif

/* core/usb_out_ep_pkg.sv */
// types shared by the output endpoint modules
package usb_out_ep_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_RECV  = 4'b0010,
    ST_DISC  = 4'b0100,
    ST_DRAIN = 4'b1000
  } rx_state_e;
  typedef enum logic [1:0] {
    HS_ACK  = 2'h0,
    HS_NAK  = 2'h1,
    HS_NYET = 2'h2
  } handshake_e;
endpackage : usb_out_ep_pkg

/* core/byte_stream_if.sv */
// valid/ready carrier between the endpoint logic and its receive fifo
`timescale 1ns/10ps
interface byte_stream_if #(parameter int WIDTH = 8);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  modport fifo_side (input push_valid, push_data, pop_ready,
                     output push_ready, pop_valid, pop_data);
  modport user_side (output push_valid, push_data, pop_ready,
                     input push_ready, pop_valid, pop_data);
endinterface : byte_stream_if

/* core/rx_byte_fifo.sv */
// flop-based receive fifo with registered ready and valid
`timescale 1ns/10ps
module rx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic       clock,  // system clock
  input  wire logic       reset,  // sync reset, high
  byte_stream_if.fifo_side bus    // push and pop sides
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic             ready_q;
  logic             valid_q;
  wire              push_fire = bus.push_valid & ready_q;
  wire              pop_fire  = valid_q & bus.pop_ready;

  // occupancy and flags
  assign count_d = CW'(count_q + CW'(push_fire) - CW'(pop_fire));
  assign bus.push_ready = ready_q;
  assign bus.pop_valid  = valid_q;
  assign bus.pop_data   = store_q[rd_ptr_q];

  // pointer and flag registers
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b1;
      valid_q  <= 1'b0;
    end else begin
      if (push_fire) wr_ptr_q <= PW'((wr_ptr_q + 1) % DEPTH);
      if (pop_fire) rd_ptr_q <= PW'((rd_ptr_q + 1) % DEPTH);
      count_q <= count_d;
      ready_q <= (count_d != CW'(DEPTH));
      valid_q <= (count_d != '0);
    end
  end

  // storage entries
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock) begin
      if (push_fire && wr_ptr_q == PW'(i)) store_q[i] <= bus.push_data;
    end
  end

  fifo_no_overflow_a: assert property (@(posedge clock) disable iff (reset)
    (count_q == CW'(DEPTH)) |-> !ready_q)
    else $error("fifo full but ready high");
endmodule : rx_byte_fifo

/* core/usb_out_ep_x.sv */
// output endpoint receive logic: buffer steering, counts and full flags
`timescale 1ns/10ps
`include "usb_out_ep_regs.svh"

// Overview of operation
// - The buffer start address is 1110, then the 8-bit base field, then 0000.
// - Each received packet is written from the programmed start address onward.
// - The low byte of the received count is read-only and resets to zero.
// - Bits 2 to 0 of the high register extend the count to 11 bits, 0 to 2047.
// - An accepted packet sets the buffer-full flag in bit 7 and blocks that buffer.
// - A packet arriving with the buffer free is processed at once and answered ACK, or NYET at high speed when no other buffer is free.
// - Once full, high speed answers NYET then NAK and full speed ACK then NAK.
// - The X and Y buffers each have their own full flag.
// - Without double buffering every packet goes to the X buffer.
// - With double buffering, toggle 0 and DATA0, data and count go to X.
// - With double buffering, toggle 1 and DATA1, data and count go to Y.
// - A stored packet raises an acknowledge interrupt to the controller.
// - The read-only toggle flips by hardware and names the expected next PID.
module usb_out_ep_x
  import usb_out_ep_pkg::*;
(
  input  wire logic        clock,        // system clock
  input  wire logic        reset,        // sync reset, high
  input  wire logic [15:0] xaddr,        // data space address
  input  wire logic [7:0]  xwdata,       // write data
  input  wire logic        xwr,          // write strobe
  input  wire logic        xrd,          // read strobe
  output logic      [7:0]  xrdata,       // read data, next cycle
  input  wire logic        out_token,    // out token pulse
  input  wire logic        token_data1,  // data pid is DATA1
  input  wire logic        high_speed,   // link runs high speed
  input  wire logic        rx_valid,     // payload byte valid
  input  wire logic [7:0]  rx_data,      // payload byte
  output logic             rx_ready,     // fifo can take a byte
  input  wire logic        rx_end,       // end of data packet
  input  wire logic        rx_good,      // packet crc good
  output logic             hs_valid,     // handshake pulse
  output logic      [1:0]  hs_code,      // handshake kind
  output logic             mem_wr,       // buffer memory write
  output logic      [15:0] mem_addr,     // buffer memory address
  output logic      [7:0]  mem_wdata,    // buffer memory data
  output logic             ack_irq       // packet stored pulse
);
  byte_stream_if #(.WIDTH(`RX_FIFO_WIDTH)) fifo_bus ();

  rx_state_e   state_q;
  rx_state_e   state_d;
  handshake_e  code_q;
  logic [7:0]  x_base_q;
  logic [7:0]  y_base_q;
  logic [10:0] x_count_q;
  logic [10:0] y_count_q;
  logic [10:0] offset_q;
  logic        x_flag_q;
  logic        y_flag_q;
  logic        double_buffer_enable_q;
  logic        toggle_q;
  logic        sel_y_q;
  logic        good_q;
  logic [7:0]  xrdata_q;
  logic        hs_valid_q;
  logic [1:0]  hs_code_q;
  logic        mem_wr_q;
  logic [15:0] mem_addr_q;
  logic [7:0]  mem_wdata_q;
  logic        mem_first_q;
  logic        ack_irq_q;

  // register decode
  wire wr_cfg   = xwr && xaddr == `OFS_OUT_CONFIG;
  wire wr_xbase = xwr && xaddr == `OFS_OUT_X_BASE;
  wire wr_xhi   = xwr && xaddr == `OFS_OUT_X_COUNT_HIGH;
  wire wr_ybase = xwr && xaddr == `OFS_OUT_Y_BASE;
  wire wr_yhi   = xwr && xaddr == `OFS_OUT_Y_COUNT_HIGH;

  // token decision terms
  wire token_idle   = out_token && state_q == ST_IDLE;
  wire sel_y_d      = double_buffer_enable_q & toggle_q;
  wire target_full  = sel_y_d ? y_flag_q : x_flag_q;
  wire pid_mismatch = double_buffer_enable_q & (token_data1 != toggle_q);
  wire other_free   = double_buffer_enable_q & (sel_y_d ? !x_flag_q : !y_flag_q);
  wire accept_tok   = token_idle && !target_full && !pid_mismatch;
  wire last_free    = high_speed && !other_free;

  // fifo push and drain
  wire pop_fire   = fifo_bus.pop_valid && fifo_bus.pop_ready;
  wire drain_done = state_q == ST_DRAIN && !fifo_bus.pop_valid;
  wire commit     = drain_done && good_q;
  wire commit_x   = commit && !sel_y_q;
  wire commit_y   = commit && sel_y_q;
  wire rx_fin     = rx_end && (state_q == ST_RECV || state_q == ST_DISC);
  assign fifo_bus.push_valid = rx_valid && state_q == ST_RECV;
  assign fifo_bus.push_data  = rx_data;
  assign fifo_bus.pop_ready  = state_q == ST_RECV || state_q == ST_DRAIN;

  // buffer start address and write position
  wire [7:0]  base_sel   = sel_y_q ? y_base_q : x_base_q;
  wire [15:0] start_addr = {`ADDR_TOP_NIBBLE, base_sel, `ADDR_LOW_NIBBLE};
  wire [15:0] wr_addr    = 16'(start_addr + {5'h00, offset_q});

  // a store and a firmware clear in one cycle leave the flag set
  // full flags: hardware set wins over firmware write
  wire x_flag_d = commit_x ? 1'b1 : (wr_xhi ? xwdata[`BIT_FULL_FLAG] : x_flag_q);
  wire y_flag_d = commit_y ? 1'b1 : (wr_yhi ? xwdata[`BIT_FULL_FLAG] : y_flag_q);

  // toggle follows every stored packet, firmware may force it to 0
  wire toggle_d = commit ? !toggle_q : ((wr_cfg && xwdata[`BIT_RESET_TOGGLE]) ? 1'b0 : toggle_q);

  // read data selection
  wire [7:0] cfg_rd  = {2'h0, toggle_q, double_buffer_enable_q, 4'h0};
  wire [7:0] xhi_rd  = {x_flag_q, 4'h0, x_count_q[10:8]};
  wire [7:0] yhi_rd  = {y_flag_q, 4'h0, y_count_q[10:8]};
  wire [7:0] rd_mux  =
    (xaddr == `OFS_OUT_CONFIG)       ? cfg_rd :
    (xaddr == `OFS_OUT_X_BASE)       ? x_base_q :
    (xaddr == `OFS_OUT_X_COUNT_LOW)  ? x_count_q[7:0] :
    (xaddr == `OFS_OUT_X_COUNT_HIGH) ? xhi_rd :
    (xaddr == `OFS_OUT_Y_BASE)       ? y_base_q :
    (xaddr == `OFS_OUT_Y_COUNT_LOW)  ? y_count_q[7:0] :
    (xaddr == `OFS_OUT_Y_COUNT_HIGH) ? yhi_rd : `RST_BYTE;

  // receive sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (token_idle) state_d = accept_tok ? ST_RECV : ST_DISC;
      ST_RECV:  if (rx_end) state_d = ST_DRAIN;
      ST_DISC:  if (rx_end) state_d = ST_IDLE;
      ST_DRAIN: if (drain_done) state_d = ST_IDLE;
    endcase
  end

  // sequencer and decision registers
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
      code_q  <= HS_ACK;
      sel_y_q <= 1'b0;
      good_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (token_idle) begin
        sel_y_q <= sel_y_d;
        code_q  <= target_full ? HS_NAK : ((accept_tok && last_free) ? HS_NYET : HS_ACK);
      end
      if (state_q == ST_RECV && rx_end) good_q <= rx_good;
    end
  end

  // write offset through the packet
  always_ff @(posedge clock) begin
    if (reset || token_idle) offset_q <= `RST_COUNT;
    else if (pop_fire && offset_q != 11'h7ff) offset_q <= 11'(offset_q + 11'h001);
  end

  // software registers
  always_ff @(posedge clock) begin
    if (reset) begin
      x_base_q <= `RST_BYTE;
      y_base_q <= `RST_BYTE;
      double_buffer_enable_q   <= 1'b0;
    end else begin
      if (wr_xbase) x_base_q <= xwdata;
      if (wr_ybase) y_base_q <= xwdata;
      if (wr_cfg) double_buffer_enable_q <= xwdata[`BIT_DOUBLE_BUFFER];
    end
  end

  // hardware status: counts, flags, toggle
  always_ff @(posedge clock) begin
    if (reset) begin
      x_count_q <= `RST_COUNT;
      y_count_q <= `RST_COUNT;
      x_flag_q  <= 1'b0;
      y_flag_q  <= 1'b0;
      toggle_q  <= 1'b0;
    end else begin
      if (commit_x) x_count_q <= offset_q;
      if (commit_y) y_count_q <= offset_q;
      x_flag_q <= x_flag_d;
      y_flag_q <= y_flag_d;
      toggle_q <= toggle_d;
    end
  end

  // outputs: read data, handshake, memory write, interrupt
  always_ff @(posedge clock) begin
    if (reset) begin
      xrdata_q    <= `RST_BYTE;
      hs_valid_q  <= 1'b0;
      hs_code_q   <= HS_ACK;
      mem_wr_q    <= 1'b0;
      mem_addr_q  <= 16'h0000;
      mem_wdata_q <= `RST_BYTE;
      mem_first_q <= 1'b0;
      ack_irq_q   <= 1'b0;
    end else begin
      if (xrd) xrdata_q <= rd_mux;
      hs_valid_q  <= rx_fin && (state_q == ST_DISC || rx_good);
      if (rx_fin) hs_code_q <= code_q;
      mem_wr_q    <= pop_fire;
      mem_first_q <= pop_fire && offset_q == `RST_COUNT;
      if (pop_fire) mem_addr_q <= wr_addr;
      if (pop_fire) mem_wdata_q <= fifo_bus.pop_data;
      ack_irq_q   <= commit;
    end
  end

  assign xrdata    = xrdata_q;
  assign hs_valid  = hs_valid_q;
  assign hs_code   = hs_code_q;
  assign mem_wr    = mem_wr_q;
  assign mem_addr  = mem_addr_q;
  assign mem_wdata = mem_wdata_q;
  assign ack_irq   = ack_irq_q;

  // the fifo never fills: bytes are popped as fast as they arrive
  // receive buffer in the payload path
  rx_byte_fifo #(
    .WIDTH (`RX_FIFO_WIDTH),
    .DEPTH (`RX_FIFO_DEPTH)
  ) u_fifo (
    .clock (clock),
    .reset (reset),
    .bus   (fifo_bus)
  );

  // fifo ready leaves ANDed with a flop of fifo ready and next state ST_RECV
  logic rx_ready_q;
  always_ff @(posedge clock) begin
    if (reset) rx_ready_q <= 1'b0;
    else rx_ready_q <= fifo_bus.push_ready && state_d == ST_RECV;
  end
  assign rx_ready = rx_ready_q & fifo_bus.push_ready;

  // checks on the behaviour above
  start_address_a: assert property (@(posedge clock) disable iff (reset)
    mem_first_q |-> mem_addr_q == {4'he, (sel_y_q ? y_base_q : x_base_q), 4'h0})
    else $error("first byte not at buffer start");

  count_readonly_a: assert property (@(posedge clock) disable iff (reset)
    (xwr && xaddr == 16'hf01a && !commit_x) |=> x_count_q == $past(x_count_q))
    else $error("low count changed by software write");

  count_high_a: assert property (@(posedge clock) disable iff (reset)
    (xrd && xaddr == 16'hf01b) |=>
      xrdata_q[6:3] == 4'h0 && xrdata_q[2:0] == $past(x_count_q[10:8]))
    else $error("high count read wrong");

  flag_set_a: assert property (@(posedge clock) disable iff (reset)
    commit_x |=> x_flag_q && x_count_q == $past(offset_q))
    else $error("x flag or count not set on store");

  firmware_clear_a: assert property (@(posedge clock) disable iff (reset)
    (wr_xhi && !xwdata[7] && !commit_x) |=> !x_flag_q)
    else $error("firmware clear of x flag lost");

  ack_free_a: assert property (@(posedge clock) disable iff (reset)
    (accept_tok && !last_free) |=> code_q == HS_ACK && state_q == ST_RECV)
    else $error("free buffer not acknowledged");

  nyet_last_a: assert property (@(posedge clock) disable iff (reset)
    (accept_tok && last_free) |=> code_q == HS_NYET)
    else $error("high speed last buffer not NYET");

  x_only_a: assert property (@(posedge clock) disable iff (reset)
    (token_idle && !double_buffer_enable_q) |=> !sel_y_q)
    else $error("y buffer used without double buffering");

  y_store_a: assert property (@(posedge clock) disable iff (reset)
    commit_y |=> y_flag_q && y_count_q == $past(offset_q) && x_count_q == $past(x_count_q))
    else $error("y store wrong");

  irq_pulse_a: assert property (@(posedge clock) disable iff (reset)
    commit |=> ack_irq_q ##1 !ack_irq_q)
    else $error("ack interrupt not one pulse");

  toggle_flip_a: assert property (@(posedge clock) disable iff (reset)
    commit |=> toggle_q != $past(toggle_q))
    else $error("toggle did not flip");

  nak_full_a: assert property (@(posedge clock) disable iff (reset)
    (token_idle && target_full) |=> state_q == ST_DISC && code_q == HS_NAK)
    else $error("full buffer not NAKed");

  // handshake and refusal checks
  good_handshake_a: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_RECV && rx_end && rx_good) |=> hs_valid_q && hs_code_q == $past(code_q))
    else $error("good packet not answered with its code");

  hs_pulse_a: assert property (@(posedge clock) disable iff (reset)
    hs_valid_q |=> !hs_valid_q)
    else $error("handshake longer than one cycle");

  ready_recv_a: assert property (@(posedge clock) disable iff (reset)
    rx_ready |-> state_q == ST_RECV)
    else $error("bytes taken outside a packet");

  disc_refuse_a: assert property (@(posedge clock) disable iff (reset)
    state_q == ST_DISC |-> !rx_ready)
    else $error("refused packet bytes taken");

  full_speed_a: assert property (@(posedge clock) disable iff (reset)
    (accept_tok && !high_speed) |=> code_q == HS_ACK)
    else $error("full speed accept not ACK");

  flag_block_a: assert property (@(posedge clock) disable iff (reset)
    (token_idle && !sel_y_d && x_flag_q) |=> state_q == ST_DISC)
    else $error("full x buffer accepted a packet");

  // buffer steering and status checks
  steer_x_a: assert property (@(posedge clock) disable iff (reset)
    (accept_tok && double_buffer_enable_q && !toggle_q) |=> !sel_y_q && state_q == ST_RECV)
    else $error("DATA0 not steered to x");

  steer_y_a: assert property (@(posedge clock) disable iff (reset)
    (accept_tok && double_buffer_enable_q && toggle_q) |=> sel_y_q && state_q == ST_RECV)
    else $error("DATA1 not steered to y");

  dup_drop_a: assert property (@(posedge clock) disable iff (reset)
    (token_idle && !target_full && pid_mismatch) |=> state_q == ST_DISC && code_q == HS_ACK)
    else $error("repeated pid not dropped with ACK");

  flags_apart_a: assert property (@(posedge clock) disable iff (reset)
    (commit_x && !wr_yhi) |=> y_flag_q == $past(y_flag_q))
    else $error("x store touched the y flag");

  count_hold_a: assert property (@(posedge clock) disable iff (reset)
    !commit_x |=> x_count_q == $past(x_count_q))
    else $error("x count changed without a store");

  toggle_clear_a: assert property (@(posedge clock) disable iff (reset)
    (wr_cfg && xwdata[`BIT_RESET_TOGGLE] && !commit) |=> !toggle_q)
    else $error("toggle reset lost");

  store_x_c: cover property (@(posedge clock) disable iff (reset) commit_x);
  store_y_c: cover property (@(posedge clock) disable iff (reset) commit_y);
  nak_c:     cover property (@(posedge clock) disable iff (reset)
    hs_valid_q && hs_code_q == HS_NAK);
  nyet_c:    cover property (@(posedge clock) disable iff (reset)
    hs_valid_q && hs_code_q == HS_NYET);
  dup_c:     cover property (@(posedge clock) disable iff (reset) token_idle && pid_mismatch);
endmodule : usb_out_ep_x

/* verif/usb_host_model.sv */
// host side model issuing out tokens and data packets
`timescale 1ns/10ps
module usb_host_model (
  input  wire logic       clock,        // system clock
  input  wire logic       rx_ready,     // device takes a byte
  output logic            out_token,    // out token pulse
  output logic            token_data1,  // data pid is DATA1
  output logic            high_speed,   // link speed
  output logic            rx_valid,     // payload byte valid
  output logic      [7:0] rx_data,      // payload byte
  output logic            rx_end,       // end of packet
  output logic            rx_good       // crc good
);
  // idle link at time zero
  initial begin
    out_token   = 1'b0;
    token_data1 = 1'b0;
    high_speed  = 1'b0;
    rx_valid    = 1'b0;
    rx_data     = 8'h5a;
    rx_end      = 1'b0;
    rx_good     = 1'b0;
  end
  // token, bytes held until taken (bounded), then end marker
  task send(input logic d1, input logic hs, input int n, input logic [7:0] first,
            input logic good, output int missed);
    int w;
    missed = 0;
    @(negedge clock);
    out_token   = 1'b1;
    token_data1 = d1;
    high_speed  = hs;
    @(negedge clock);
    out_token = 1'b0;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_data  = first + 8'(i);
      for (w = 0; w < 4 && rx_ready !== 1'b1; w++) @(negedge clock);
      if (rx_ready !== 1'b1) missed++;  // wait ran out, byte dropped
      @(negedge clock);
    end
    rx_valid = 1'b0;
    rx_data  = ~rx_data;  // released line shows no stale byte
    rx_end   = 1'b1;
    rx_good  = good;
    @(negedge clock);
    rx_end  = 1'b0;
    rx_good = 1'b0;
  endtask : send
endmodule : usb_host_model

/* verif/testbench.sv */
// self-checking bench for the output endpoint receive logic
`timescale 1ns/10ps
`include "usb_out_ep_regs.svh"
module testbench;
  import usb_out_ep_pkg::*;
  logic        clock, reset, xwr, xrd, out_token, token_data1, high_speed;
  logic        rx_valid, rx_ready, rx_end, rx_good, hs_valid, mem_wr, ack_irq;
  logic [15:0] xaddr, mem_addr;
  logic [7:0]  xwdata, xrdata, rx_data, mem_wdata;
  logic [1:0]  hs_code;
  int          n_errors, n_compared, n_irq;
  logic [15:0] mem_a[$];
  logic [7:0]  mem_d[$];
  logic [1:0]  hs_q[$];

  usb_out_ep_x DUT (.clock(clock), .reset(reset), .xaddr(xaddr), .xwdata(xwdata),
    .xwr(xwr), .xrd(xrd), .xrdata(xrdata), .out_token(out_token),
    .token_data1(token_data1), .high_speed(high_speed), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .rx_end(rx_end), .rx_good(rx_good),
    .hs_valid(hs_valid), .hs_code(hs_code), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .ack_irq(ack_irq));
  usb_host_model host (.clock(clock), .rx_ready(rx_ready), .out_token(out_token),
    .token_data1(token_data1), .high_speed(high_speed), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_good(rx_good));

  // clock generator
  initial clock = 1'b0;
  always #5 clock = ~clock;
  // capture memory writes, handshakes and interrupts
  always @(negedge clock) begin
    if (mem_wr === 1'b1) begin
      mem_a.push_back(mem_addr);
      mem_d.push_back(mem_wdata);
    end
    if (hs_valid === 1'b1) hs_q.push_back(hs_code);
    if (ack_irq === 1'b1) n_irq++;
  end

  task check_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_reg
  task check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_word
  // one-cycle strobes on the data space bus
  task reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    xaddr  = a;
    xwdata = d;
    xwr    = 1'b1;
    @(negedge clock);
    xwr = 1'b0;
  endtask : reg_wr
  task reg_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(negedge clock);
    xaddr = a;
    xrd   = 1'b1;
    @(negedge clock);
    xrd = 1'b0;
    check_reg(xrdata, exp, what);
  endtask : reg_chk
  // one packet from the host, then its handshake, interrupt and stored bytes
  task packet(input logic d1, input logic hs, input int n, input logic [7:0] first,
              input logic [15:0] start, input logic [1:0] code, input bit stored);
    int irq0;
    int missed;
    mem_a.delete();
    mem_d.delete();
    hs_q.delete();
    irq0 = n_irq;
    host.send(d1, hs, n, first, 1'b1, missed);
    repeat (12) @(negedge clock);
    check_word(16'(missed), stored ? 16'h0000 : 16'(n), "bytes refused");
    check_word(16'(hs_q.size()), 16'h0001, "handshakes");
    if (hs_q.size() > 0) check_word(16'(hs_q[0]), 16'(code), "handshake code");
    check_word(16'(n_irq - irq0), stored ? 16'h0001 : 16'h0000, "irq pulses");
    check_word(16'(mem_a.size()), stored ? 16'(n) : 16'h0000, "bytes written");
    for (int i = 0; i < mem_a.size(); i++) begin
      check_word(mem_a[i], start + 16'(i), "write address");
      check_reg(mem_d[i], first + 8'(i), "write data");
    end
  endtask : packet

  task test_reset_regs;
    reg_chk(`OFS_OUT_X_BASE, 8'h00, "base reset");
    reg_wr(`OFS_OUT_X_COUNT_LOW, 8'hff);
    reg_chk(`OFS_OUT_X_COUNT_LOW, 8'h00, "count low");
    reg_wr(`OFS_OUT_X_COUNT_HIGH, 8'h7f);
    reg_chk(`OFS_OUT_X_COUNT_HIGH, 8'h00, "count high");
    reg_chk(`OFS_OUT_CONFIG, 8'h00, "config reset");
    reg_wr(16'hf0ff, 8'ha5);
    reg_chk(16'hf0ff, 8'h00, "unmapped");
    $display("test reset_regs done");
  endtask : test_reset_regs
  task test_x_packet;
    reg_wr(`OFS_OUT_X_BASE, 8'h12);
    reg_chk(`OFS_OUT_X_BASE, 8'h12, "base");
    packet(1'b0, 1'b0, 3, 8'ha1, 16'he120, HS_ACK, 1'b1);
    reg_chk(`OFS_OUT_X_COUNT_LOW, 8'h03, "count low");
    reg_chk(`OFS_OUT_X_COUNT_HIGH, 8'h80, "full flag");
    reg_chk(`OFS_OUT_CONFIG, 8'h20, "toggle");
    $display("test x_packet done");
  endtask : test_x_packet
  task test_full_nak;
    packet(1'b1, 1'b0, 2, 8'hb1, 16'he120, HS_NAK, 1'b0);
    reg_chk(`OFS_OUT_X_COUNT_LOW, 8'h03, "count kept");
    $display("test full_nak done");
  endtask : test_full_nak
  task test_high_speed;
    reg_wr(`OFS_OUT_X_COUNT_HIGH, 8'h00);
    reg_chk(`OFS_OUT_X_COUNT_HIGH, 8'h00, "flag cleared");
    packet(1'b1, 1'b1, 2, 8'hc1, 16'he120, HS_NYET, 1'b1);
    reg_chk(`OFS_OUT_X_COUNT_LOW, 8'h02, "count low");
    packet(1'b0, 1'b1, 1, 8'hd1, 16'he120, HS_NAK, 1'b0);
    reg_chk(`OFS_OUT_CONFIG, 8'h00, "toggle");
    $display("test high_speed done");
  endtask : test_high_speed
  task test_double;
    reg_wr(`OFS_OUT_X_COUNT_HIGH, 8'h00);
    reg_wr(`OFS_OUT_Y_BASE, 8'h34);
    reg_wr(`OFS_OUT_CONFIG, 8'h12);
    reg_chk(`OFS_OUT_CONFIG, 8'h10, "double_buffer_enable on");
    packet(1'b0, 1'b0, 1, 8'he1, 16'he120, HS_ACK, 1'b1);
    reg_chk(`OFS_OUT_CONFIG, 8'h30, "toggle");
    packet(1'b1, 1'b0, 2, 8'hf1, 16'he340, HS_ACK, 1'b1);
    reg_chk(`OFS_OUT_Y_COUNT_LOW, 8'h02, "y count");
    reg_chk(`OFS_OUT_Y_COUNT_HIGH, 8'h80, "y flag");
    reg_chk(`OFS_OUT_X_COUNT_LOW, 8'h01, "x count");
    reg_chk(`OFS_OUT_X_COUNT_HIGH, 8'h80, "x flag");
    $display("test double done");
  endtask : test_double
  task test_dup_pid;
    reg_wr(`OFS_OUT_X_COUNT_HIGH, 8'h00);
    reg_wr(`OFS_OUT_Y_COUNT_HIGH, 8'h00);
    packet(1'b1, 1'b0, 2, 8'h21, 16'he120, HS_ACK, 1'b0);
    reg_chk(`OFS_OUT_X_COUNT_HIGH, 8'h00, "dup x flag");
    reg_chk(`OFS_OUT_CONFIG, 8'h10, "dup toggle");
    $display("test dup_pid done");
  endtask : test_dup_pid
  task test_bad_crc;
    int missed;
    int irq0;
    hs_q.delete();
    irq0 = n_irq;
    host.send(1'b0, 1'b0, 2, 8'h31, 1'b0, missed);
    repeat (12) @(negedge clock);
    check_word(16'(missed), 16'h0000, "bad crc bytes taken");
    check_word(16'(hs_q.size()), 16'h0000, "bad crc handshake");
    check_word(16'(n_irq - irq0), 16'h0000, "bad crc irq");
    reg_chk(`OFS_OUT_X_COUNT_LOW, 8'h01, "bad crc count");
    reg_chk(`OFS_OUT_X_COUNT_HIGH, 8'h00, "bad crc flag");
    reg_chk(`OFS_OUT_CONFIG, 8'h10, "bad crc toggle");
    $display("test bad_crc done");
  endtask : test_bad_crc

  task stop_test;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    stop_test();
  end
  // reset, then the scenarios in order
  initial begin
    reset  = 1'b1;
    xaddr  = 16'h0000;
    xwdata = 8'h00;
    xwr    = 1'b0;
    xrd    = 1'b0;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    test_reset_regs();
    test_x_packet();
    test_full_nak();
    test_high_speed();
    test_double();
    test_dup_pid();
    test_bad_crc();
    stop_test();
  end
endmodule : testbench
